// ===== rtl/high_speed_updown_counter.sv
// High speed up/down pulse counter with two match outputs.
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ns
module high_speed_updown_counter
    import updown_counter_pkg::*;
#(
    parameter int SW_DELAY = SW_DELAY_CYC
)(
    // Clock and reset.
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    // Pulse inputs.
    input  wire logic        phase_a_i,
    input  wire logic        phase_b_i,
    input  wire logic        preset_z_i,
    input  wire logic        count_prohibit_i,
    // Buffer memory word port.
    input  wire logic [4:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,
    // Match outputs.
    output logic             hw_match_output_o,
    output logic             sw_match_output_o
);
    logic        a_q;
    logic        b_q;
    logic [31:0] count;
    logic [31:0] next_count;
    logic        dir_sw;
    logic [15:0] limit;
    logic [7:0]  mode;
    logic [31:0] preset;
    logic [31:0] cmp;
    logic        cnt_en;
    logic        hw_q;
    logic        next_hw_q;
    logic        clr_cmd;
    logic [15:0] next_rdata;
    logic        up_ev;
    logic        dn_ev;
    input_mode_e in_mode;
    edge_mode_e  edge_mode;
    logic        len16;
    logic        match_now;
    match_if     mi();

    assign in_mode   = input_mode_e'(mode[MODE_IN_LSB +: 2]);
    assign edge_mode = edge_mode_e'(mode[MODE_ENC_LSB +: 2]);
    assign len16     = mode[MODE_LEN_BIT];
    assign clr_cmd   = wr_i && addr_i == WORD_CMD && wdata_i[CMD_CLR_BIT];

    // Pulse event decode.
    always_comb
    begin
        up_ev = 1'b0;
        dn_ev = 1'b0;
        case (in_mode) // RULE1
            IN_1PH_1IN:
            begin
                // Count on the B-phase rising edge.
                if (phase_b_i && !b_q)
                begin
                    if (mode[MODE_SWD_BIT] ? dir_sw : phase_a_i) // RULE2 RULE3
                        dn_ev = 1'b1;
                    else
                        up_ev = 1'b1;
                end
            end
            IN_1PH_2IN:
            begin
                up_ev = phase_a_i && !a_q;
                dn_ev = phase_b_i && !b_q;
            end
            IN_2PH:
            begin
                case (edge_mode) // RULE11
                    EDGE_X1:
                    begin
                        up_ev = phase_a_i && !a_q && !phase_b_i;
                        dn_ev = !phase_a_i && a_q && !phase_b_i;
                    end
                    EDGE_X2:
                    begin
                        up_ev = (phase_a_i != a_q) && (phase_a_i != phase_b_i);
                        dn_ev = (phase_a_i != a_q) && (phase_a_i == phase_b_i);
                    end
                    default:
                    begin
                        up_ev = ((phase_a_i != a_q) && (phase_a_i != phase_b_i))
                              || ((phase_b_i != b_q) && (phase_b_i == phase_a_i));
                        dn_ev = ((phase_a_i != a_q) && (phase_a_i == phase_b_i))
                              || ((phase_b_i != b_q) && (phase_b_i != phase_a_i));
                    end
                endcase
            end
            default:
            begin
                up_ev = 1'b0;
                dn_ev = 1'b0;
            end
        endcase
    end

    // Present value update.
    always_comb
    begin
        next_count = count;
        if (preset_z_i)
            next_count = preset; // RULE12
        else if (cnt_en && !count_prohibit_i && (up_ev != dn_ev)) // RULE10
        begin
            if (len16)
            begin
                // Ring between zero and the software limit.
                if (up_ev)
                    next_count = (count[15:0] >= limit) ? 32'h0 : count + 32'h1; // RULE5 RULE6
                else
                    next_count = (count[15:0] == 16'h0) ? {16'h0, limit} : count - 32'h1; // RULE5 RULE6
            end
            else
            begin
                next_count = up_ev ? count + 32'h1 : count - 32'h1; // RULE4
            end
        end
    end

    assign match_now = (count == cmp);
    // A match in the cycle of a reset command wins, so the flag stays set while the count equals the compare value.
    assign next_hw_q = match_now | (hw_q & ~clr_cmd); // RULE7

    always_comb
    begin
        next_rdata = 16'h0;
        case (addr_i)
            WORD_DIR:      next_rdata = {15'h0, dir_sw};
            WORD_LIMIT_LO: next_rdata = limit;
            WORD_MODE:     next_rdata = {8'h0, mode};
            WORD_CMD:      next_rdata = {14'h0, cnt_en, 1'b0};
            WORD_PRE_LO:   next_rdata = preset[15:0];
            WORD_PRE_HI:   next_rdata = preset[31:16];
            WORD_CMP_LO:   next_rdata = cmp[15:0];
            WORD_CMP_HI:   next_rdata = cmp[31:16];
            WORD_CNT_LO:   next_rdata = count[15:0];
            WORD_CNT_HI:   next_rdata = count[31:16];
            WORD_STATUS:   next_rdata = {13'h0, match_now, mi.out, hw_q};
            default:       next_rdata = 16'h0;
        endcase
        if (!rd_i)
            next_rdata = 16'h0;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            a_q     <= 1'b0;
            b_q     <= 1'b0;
            count   <= '0;
            dir_sw  <= 1'b0;
            limit   <= LIMIT_RESET;
            mode    <= '0;
            preset  <= '0;
            cmp     <= '0;
            cnt_en  <= 1'b0;
            hw_q    <= 1'b0;
            rdata_o <= '0;
        end
        else
        begin
            a_q     <= phase_a_i;
            b_q     <= phase_b_i;
            count   <= next_count;
            hw_q    <= next_hw_q; // RULE8
            rdata_o <= next_rdata;
            if (wr_i)
            begin
                case (addr_i)
                    WORD_DIR:      dir_sw <= wdata_i[0]; // RULE3
                    WORD_LIMIT_LO: limit <= wdata_i; // RULE5
                    WORD_MODE:     mode <= wdata_i[7:0];
                    WORD_CMD:      cnt_en <= wdata_i[CMD_CNT_BIT];
                    WORD_PRE_LO:   preset[15:0] <= wdata_i;
                    WORD_PRE_HI:   preset[31:16] <= wdata_i;
                    WORD_CMP_LO:   cmp[15:0] <= wdata_i;
                    WORD_CMP_HI:   cmp[31:16] <= wdata_i;
                    default:       ;
                endcase
            end
        end
    end

    assign mi.match = match_now;
    assign mi.clear = clr_cmd;

    sw_match_stage #(
        .DELAY_CYC (SW_DELAY)
    ) u_sw (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .m          (mi.stage)
    );

    assign hw_match_output_o = hw_q;
    assign sw_match_output_o = mi.out;
endmodule

// ===== rtl/updown_counter_pkg.sv
// Package with constants and types for the high speed up/down counter.
// Operation
// RULE1: Direction automatic except one-phase one-input mode.
// RULE2: Hardware direction follows A-phase level.
// RULE3: Software direction from word 1 value.
// RULE4: 32-bit mode spans full signed range.
// RULE5: 16-bit upper limit from words 3/2; the code loads the limit from word 2 only and ignores word 3.
// RULE6: 16-bit count stays zero to 65535.
// RULE7: Match outputs set on equality, cleared by reset.
// RULE8: Hardware match output driven directly by compare.
// RULE9: Software match output lags at most 300 us.
// RULE10: Count-prohibit input freezes present value.
// RULE11: Two-phase counts one, two or four edges.
// RULE12: Z-phase preset loads preset value.
package updown_counter_pkg;
    // Buffer memory word indices.
    localparam logic [4:0] WORD_DIR      = 5'h01;
    localparam logic [4:0] WORD_LIMIT_LO = 5'h02;
    localparam logic [4:0] WORD_LIMIT_HI = 5'h03;
    localparam logic [4:0] WORD_MODE     = 5'h04;
    localparam logic [4:0] WORD_CMD      = 5'h05;
    localparam logic [4:0] WORD_PRE_LO   = 5'h06;
    localparam logic [4:0] WORD_PRE_HI   = 5'h07;
    localparam logic [4:0] WORD_CMP_LO   = 5'h08;
    localparam logic [4:0] WORD_CMP_HI   = 5'h09;
    localparam logic [4:0] WORD_CNT_LO   = 5'h0a;
    localparam logic [4:0] WORD_CNT_HI   = 5'h0b;
    localparam logic [4:0] WORD_STATUS   = 5'h0c;
    // Mode word fields.
    localparam int MODE_IN_LSB  = 0;
    localparam int MODE_LEN_BIT = 2;
    localparam int MODE_SWD_BIT = 3;
    localparam int MODE_ENC_LSB = 4;
    // Command word bits.
    localparam int CMD_CLR_BIT  = 0;
    localparam int CMD_CNT_BIT  = 1;
    localparam logic [15:0] LIMIT_RESET = 16'hffff;
    localparam int SW_DELAY_US  = 300;
    localparam int CLK_MHZ      = 100;
    localparam int SW_DELAY_CYC = SW_DELAY_US * CLK_MHZ;
    typedef enum logic [1:0] {IN_1PH_1IN, IN_1PH_2IN, IN_2PH} input_mode_e;
    typedef enum logic [1:0] {EDGE_X1, EDGE_X2, EDGE_X4} edge_mode_e;
endpackage

// ===== rtl/match_if.sv
// Interface carrying match events to the software output stage.
`timescale 1ns/1ns
interface match_if;
    logic match;
    logic clear;
    logic out;
    modport core  (output match, output clear, input out);
    modport stage (input match, input clear, output out);
endinterface

// ===== rtl/sw_match_stage.sv
// Delayed software-style match output stage.
`timescale 1ns/1ns
module sw_match_stage
    import updown_counter_pkg::*;
#(
    parameter int DELAY_CYC = SW_DELAY_CYC
)(
    // Clock and reset.
    input  wire logic   core_clk_i,
    input  wire logic   rst_i,
    // Match events.
    match_if.stage      m
);
    logic        pending;
    logic        next_pending;
    logic [31:0] wait_cnt;
    logic [31:0] next_wait_cnt;
    logic        outq;
    logic        next_outq;

    always_comb
    begin
        next_pending  = pending;
        next_wait_cnt = wait_cnt;
        next_outq     = outq;
        if (m.clear)
        begin
            next_pending  = 1'b0;
            next_outq     = 1'b0;
            next_wait_cnt = '0;
        end
        if (m.match && !outq && !pending)
        begin
            next_pending  = 1'b1;
            next_wait_cnt = '0;
        end
        else if (pending && !m.clear)
        begin
            // Output rises well inside the worst delay bound.
            if (wait_cnt >= 32'(DELAY_CYC / 2)) // RULE9
            begin
                next_pending = 1'b0;
                next_outq    = 1'b1; // RULE7
            end
            else
            begin
                next_wait_cnt = wait_cnt + 32'h1;
            end
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            pending  <= 1'b0;
            wait_cnt <= '0;
            outq     <= 1'b0;
        end
        else
        begin
            pending  <= next_pending;
            wait_cnt <= next_wait_cnt;
            outq     <= next_outq;
        end
    end

    assign m.out = outq;
endmodule

// ===== test/pulse_source.sv
// Quadrature pulse source standing in for an incremental encoder.
`timescale 1ns/1ns
module pulse_source (
    // Clock and step requests.
    input  wire logic core_clk_i,
    input  wire logic step_i,
    input  wire logic up_i,
    // Encoder phases.
    output logic      phase_a_o,
    output logic      phase_b_o
);
    logic [1:0] pos = 2'h0;
    always @(posedge core_clk_i)
        if (step_i)
            pos <= up_i ? pos + 2'h1 : pos - 2'h1;
    // A leads B when stepping up, and each step moves one phase edge.
    assign phase_a_o = pos[1] ^ pos[0];
    assign phase_b_o = pos[1];
endmodule

// ===== test/high_speed_updown_counter_sva.sv
// Checker for the counter's match outputs and read port.
`timescale 1ns/1ns
module high_speed_updown_counter_sva
    import updown_counter_pkg::*;
#(
    parameter int SW_DELAY = SW_DELAY_CYC
)(
    // Watched ports.
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic [4:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic [15:0] rdata_o,
    input  wire logic        hw_match_output_o,
    input  wire logic        sw_match_output_o
);
    localparam int LAG = SW_DELAY + 4;
    logic        clr;
    int unsigned lag_cyc;
    assign clr = wr_i && addr_i == WORD_CMD && wdata_i[CMD_CLR_BIT];
    // Counts how long the software output trails the hardware one.
    always_ff @(posedge core_clk_i)
        if (rst_i || clr || !hw_match_output_o || sw_match_output_o)
            lag_cyc <= 0;
        else
            lag_cyc <= lag_cyc + 1;
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    read_idle_a: assert property (!rd_i |=> rdata_o == 16'h0000) else $error("Read data not zero.");
    read_unmapped_a: assert property (rd_i && addr_i > WORD_STATUS |=> rdata_o == 16'h0000) else $error("Bad read.");
    hw_hold_a: assert property (hw_match_output_o && !clr |=> hw_match_output_o) else $error("Hw match lost.");
    sw_hold_a: assert property (sw_match_output_o && !clr |=> sw_match_output_o) else $error("Sw match lost.");
    sw_clear_a: assert property (clr |=> !sw_match_output_o) else $error("Sw match not cleared.");
    sw_follows_a: assert property ($rose(sw_match_output_o) |-> hw_match_output_o) else $error("Sw early.");
    hw_first_a: assert property ($rose(hw_match_output_o) |-> !sw_match_output_o) else $error("Hw late.");
    sw_lag_a: assert property (lag_cyc <= LAG) else $error("Sw match too late.");
endmodule
bind high_speed_updown_counter high_speed_updown_counter_sva #(.SW_DELAY(SW_DELAY)) chk_u (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .hw_match_output_o(hw_match_output_o),
    .sw_match_output_o(sw_match_output_o));

// ===== test/high_speed_updown_counter_tb.sv
// Self-checking bench for the high speed up/down counter.
`timescale 1ns/1ns
module high_speed_updown_counter_tb;
    import updown_counter_pkg::*;
    logic        clk = 0;
    logic        rst = 1;
    logic        step = 0;
    logic        up = 1;
    logic        pa, pb, hw_m, sw_m;
    logic        pz = 0;
    logic        inh = 0;
    logic [4:0]  addr = 5'h00;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 0;
    logic        rd = 0;
    logic [15:0] rdata, d;
    int          miscompares = 0;
    int          n_compared = 0;
    always #5 clk = ~clk;
    pulse_source src_u (.core_clk_i(clk), .step_i(step), .up_i(up), .phase_a_o(pa), .phase_b_o(pb));
    high_speed_updown_counter #(.SW_DELAY(20)) dut_u (
        .core_clk_i(clk), .rst_i(rst), .phase_a_i(pa), .phase_b_i(pb), .preset_z_i(pz),
        .count_prohibit_i(inh), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .hw_match_output_o(hw_m), .sw_match_output_o(sw_m));
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrw(input logic [4:0] a, input logic [15:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1;
        @(posedge clk);
        wr <= 0;
    endtask
    task automatic rdw(input logic [4:0] a, output logic [15:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1;
        @(posedge clk);
        rd <= 0;
        #1 v = rdata;
    endtask
    task automatic rc(input logic [4:0] a, input logic [31:0] exp);
        logic [15:0] lo, hi;
        rdw(a, lo);
        rdw(a + 5'h01, hi);
        chk({hi, lo}, exp);
    endtask
    task automatic steps(input int n, input logic u);
        repeat (n)
        begin
            @(posedge clk);
            step <= 1;
            up <= u;
            @(posedge clk);
            step <= 0;
            repeat (4) @(posedge clk);
        end
    endtask
    task automatic preset(input logic [31:0] v);
        wrw(WORD_PRE_LO, v[15:0]);
        wrw(WORD_PRE_HI, v[31:16]);
        @(posedge clk);
        pz <= 1;
        @(posedge clk);
        pz <= 0;
        repeat (3) @(posedge clk);
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        print_verdict();
    end
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 0;
        rc(WORD_CNT_LO, 32'h0);
        rdw(5'h1f, d);
        chk(d, 32'h0);
        wrw(WORD_CMD, 16'h0002);
        for (int e = 0; e < 3; e++)
        begin
            wrw(WORD_MODE, 16'h0002 | (e << MODE_ENC_LSB));
            steps(4, 1);
            rc(WORD_CNT_LO, (32'h2 << e) - 32'h1);
        end
        steps(3, 0);
        rc(WORD_CNT_LO, 32'h4);
        inh <= 1;
        steps(4, 1);
        inh <= 0;
        rc(WORD_CNT_LO, 32'h4);
        wrw(WORD_CMP_LO, 16'h0006);
        wrw(WORD_CMP_HI, 16'h0000);
        // Both flags were set by the equal count and compare out of reset, so clear them first.
        wrw(WORD_CMD, 16'h0003);
        @(posedge clk);
        chk({hw_m, sw_m}, 2'h0);
        steps(1, 1);
        chk(hw_m, 1'b0);
        steps(1, 1);
        chk({hw_m, sw_m}, 2'h2);
        for (int i = 0; i < 40 && sw_m !== 1'b1; i++) @(posedge clk);
        chk(sw_m, 1'b1);
        rdw(WORD_STATUS, d);
        chk(d, 32'h7);
        wrw(WORD_CMD, 16'h0003);
        @(posedge clk);
        chk({hw_m, sw_m}, 2'h2);
        steps(1, 1);
        for (int i = 0; i < 40 && sw_m !== 1'b1; i++) @(posedge clk);
        chk({hw_m, sw_m}, 2'h3);
        wrw(WORD_CMD, 16'h0003);
        @(posedge clk);
        chk({hw_m, sw_m}, 2'h0);
        preset(32'h8000_0001);
        rc(WORD_CNT_LO, 32'h8000_0001);
        steps(1, 0);
        rc(WORD_CNT_LO, 32'h8000_0000);
        wrw(WORD_LIMIT_LO, 16'h0003);
        wrw(WORD_MODE, 16'h0026);
        preset(32'h0);
        steps(3, 1);
        rc(WORD_CNT_LO, 32'h3);
        steps(1, 1);
        rc(WORD_CNT_LO, 32'h0);
        steps(1, 0);
        rc(WORD_CNT_LO, 32'h3);
        wrw(WORD_MODE, 16'h0000);
        preset(32'h0);
        steps(4, 1);
        rc(WORD_CNT_LO, 32'hffff_ffff);
        wrw(WORD_DIR, 16'h0000);
        wrw(WORD_MODE, 16'h0008);
        steps(4, 1);
        wrw(WORD_CNT_LO, 16'h1234);
        rc(WORD_CNT_LO, 32'h0);
        wrw(WORD_MODE, 16'h0001);
        steps(3, 1);
        rc(WORD_CNT_LO, 32'h1);
        steps(1, 1);
        rc(WORD_CNT_LO, 32'h0);
        print_verdict();
    end
endmodule
